/* bench/host_cpu_model.sv */
`timescale 1ns/1ps
module host_cpu_model
	import local_bus_pkg::*;
(
	input  wire logic        sys_clk,
	output logic             hostWr,
	output logic             hostRd,
	output logic      [12:0] hostAddr,
	output logic      [15:0] hostWrData,
	input  wire logic [15:0] hostRdData
);
	initial begin
		{hostWr, hostRd, hostAddr, hostWrData} = '0;
	end
	// idle lines are inverted so a stale address is never reused by accident
	task automatic hacc(input logic wr, input logic [12:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge sys_clk);
		hostWr     <= wr;
		hostRd     <= !wr;
		hostAddr   <= a;
		hostWrData <= d;
		@(posedge sys_clk);
		{hostWr, hostRd} <= 2'b00;
		hostAddr   <= ~a;
		hostWrData <= ~d;
		#1 q = hostRdData; // a read of the clear cell drops the irq
	endtask
endmodule

/* bench/local_bus_periphery_logic_sva.sv */
`timescale 1ns/1ps
module local_bus_periphery_logic_sva
	import local_bus_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        ioWr,
	input wire logic        ioRd,
	input wire logic [9:0]  ioAddr,
	input wire logic [7:0]  ioWrData,
	input wire logic [7:0]  ioRdData,
	input wire logic        memWr,
	input wire logic        memRd,
	input wire logic [19:0] memAddr,
	input wire logic        hostWr,
	input wire logic        hostRd,
	input wire logic [12:0] hostAddr,
	input wire logic [15:0] hostWrData,
	input wire logic [6:0]  hostIrq,
	input wire logic [15:0] localIrq,
	input wire logic        sramSel,
	input wire pins_s       pins,
	input wire logic        supplyOff,
	input wire logic        nmiLocal,
	input wire logic        nmiHost,
	input wire logic        localCpuReset
);
	logic [2:0]  selReg;
	logic [15:0] nmiVal;
	logic [4:0]  stPins;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	assign stPins = {pins.chargeWarn, pins.batteryLow, pins.runSw,
		pins.updateSw, pins.mainsOk};
	// shadows of settings; the nmi interval has no read-back, the irq select reads back at HOST_IRQ_SELECT
	always_ff @(posedge sys_clk) begin
		if (reset)
			selReg <= HOST_IRQ_OFF;
		else if (hostWr && hostAddr == HOST_IRQ_SELECT)
			selReg <= hostWrData[2:0];
	end
	always_ff @(posedge sys_clk) begin
		if (reset)
			nmiVal <= NMI_INTERVAL_RESET;
		else if (ioWr && ioAddr == IO_NMI_LOW)
			nmiVal[7:0] <= ioWrData;
		else if (ioWr && ioAddr == IO_NMI_HIGH)
			nmiVal[15:8] <= ioWrData;
	end
	a_host_irq_set: assert property (
		memWr && memAddr == MEM_HOST_IRQ_CELL && selReg != HOST_IRQ_OFF
		|-> ##2 hostIrq[selReg]) else $error("host irq not raised");
	a_host_irq_clear: assert property (
		hostRd && hostAddr == HOST_CLR_HOST_CELL
		&& !(memWr && memAddr == MEM_HOST_IRQ_CELL) |-> ##2 hostIrq == 7'h00)
		else $error("host irq not dropped");
	a_local_irq_clear: assert property (
		memRd && memAddr == MEM_LOCAL_CLR_CELL
		&& !(hostWr && hostAddr == HOST_SET_LOCAL_CELL)
		|-> ##2 localIrq == 16'h0000) else $error("local irq not dropped");
	a_sram_blocked: assert property (
		(!pins.powerGood)[*5] |-> !sramSel) else $error("sram not locked");
	a_status_bits: assert property (
		($stable(stPins))[*5] ##0 (ioRd && ioAddr == IO_BOARD_STATUS)
		|-> ##1 ioRdData == {3'b000, $past(stPins)})
		else $error("status byte wrong");
	a_shutdown_set: assert property (
		ioWr && ioAddr == IO_SUPPLY_CTRL && ioWrData[0] |=> supplyOff[*3])
		else $error("shutdown not asserted");
	a_nmi_host_copy: assert property (
		nmiHost |-> nmiLocal) else $error("host nmi without local nmi");
	a_nmi_zero_off: assert property (
		nmiLocal |-> $past(nmiVal) != 16'h0000) else $error("nmi while off");
	a_nmi_one_pulse: assert property (
		nmiLocal |=> (!nmiLocal)[*3]) else $error("nmi pulse too long");
	a_reset_key_follow: assert property (
		($stable(pins.resetKey))[*5] |-> localCpuReset == pins.resetKey)
		else $error("local reset does not follow key");
endmodule

bind local_bus_periphery_logic local_bus_periphery_logic_sva
	local_bus_periphery_logic_sva_i (.sys_clk(sys_clk), .reset(reset),
	.ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr), .ioWrData(ioWrData),
	.ioRdData(ioRdData), .memWr(memWr), .memRd(memRd), .memAddr(memAddr),
	.hostWr(hostWr), .hostRd(hostRd), .hostAddr(hostAddr),
	.hostWrData(hostWrData), .hostIrq(hostIrq), .localIrq(localIrq),
	.sramSel(sramSel), .pins(pins), .supplyOff(supplyOff),
	.nmiLocal(nmiLocal), .nmiHost(nmiHost), .localCpuReset(localCpuReset));

/* bench/test_local_bus_periphery_logic.sv */
`timescale 1ns/1ps
module test_local_bus_periphery_logic
	import local_bus_pkg::*;
;
	logic        sys_clk, reset, ioWr, ioRd, memWr, memRd, memRdHit;
	logic        hostWr, hostRd, hostRdHit, sramSel, sramWe, supplyOff;
	logic        nmiLocal, nmiHost, localCpuReset, optLinkSel;
	logic [9:0]  ioAddr;
	logic [7:0]  ioWrData, ioRdData;
	logic [12:0] hostAddr;
	logic [15:0] memWrData, memRdData, hostWrData, hostRdData, localIrq, rd;
	logic [19:0] memAddr, sramAddr;
	logic [6:0]  hostIrq, segHigh, segLow;
	pins_s       pins;
	int          failures, compares, n;
	localparam logic [6:0] SEG [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
		7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E,
		7'h79, 7'h71};
	localparam logic [9:0] OL [4] = '{10'h27F, 10'h280, 10'h29F, 10'h2A0};
	localparam logic [4:0] PG [3] = '{5'h00, 5'h1F, 5'h0A};

	local_bus_periphery_logic #(.ERR_ALT_COUNT(20), .NMI_TICK_COUNT(4))
	local_bus_periphery_logic_i (.sys_clk(sys_clk), .reset(reset),
		.ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr), .ioWrData(ioWrData),
		.ioRdData(ioRdData), .memWr(memWr), .memRd(memRd),
		.memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
		.memRdHit(memRdHit), .hostWr(hostWr), .hostRd(hostRd),
		.hostAddr(hostAddr), .hostWrData(hostWrData),
		.hostRdData(hostRdData), .hostRdHit(hostRdHit), .hostIrq(hostIrq),
		.localIrq(localIrq), .sramSel(sramSel), .sramWe(sramWe),
		.sramAddr(sramAddr), .segHigh(segHigh), .segLow(segLow),
		.pins(pins), .supplyOff(supplyOff), .nmiLocal(nmiLocal),
		.nmiHost(nmiHost), .localCpuReset(localCpuReset),
		.optLinkSel(optLinkSel));
	host_cpu_model host_cpu_model_i (.sys_clk(sys_clk), .hostWr(hostWr),
		.hostRd(hostRd), .hostAddr(hostAddr), .hostWrData(hostWrData),
		.hostRdData(hostRdData));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// rd carries the link select in bit 15 and the read byte in bits 7:0
	task automatic io(input logic wr, input logic [9:0] a,
		input logic [7:0] d);
		@(posedge sys_clk);
		{ioWr, ioRd} <= {wr, !wr};
		ioAddr   <= a;
		ioWrData <= d;
		@(posedge sys_clk);
		{ioWr, ioRd} <= 2'b00;
		ioAddr   <= ~a;
		ioWrData <= ~d;
		#1 rd = {optLinkSel, 7'h00, ioRdData};
	endtask
	task automatic mac(input logic wr, input logic [19:0] a,
		input logic [15:0] d);
		@(posedge sys_clk);
		{memWr, memRd} <= {wr, !wr};
		memAddr   <= a;
		memWrData <= d;
		@(posedge sys_clk);
		{memWr, memRd} <= 2'b00;
		memAddr   <= ~a;
		memWrData <= ~d;
		#1 rd = memRdData;
	endtask
	task automatic seg_chk(input logic [7:0] v);
		cyc(2);
		chk({segHigh, 2'b00, segLow},
			{v[7:4] == 4'h0 ? 7'h00 : SEG[v[7:4]], 2'b00, SEG[v[3:0]]});
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic end_sim();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		end_sim();
	end

	initial begin
		{ioWr, ioRd, memWr, memRd, ioAddr, ioWrData, memAddr, memWrData} = '0;
		failures = 0;
		compares = 0;
		pins = '0;
		pins.powerGood = 1'b1;
		pins.localIrqJumper = 16'h0200; // default jumper
		reset = 1'b1;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		cyc(4);
		seg_chk(8'h00);
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			{pins.chargeWarn, pins.batteryLow, pins.runSw, pins.updateSw,
				pins.mainsOk} <= 5'(i < 5 ? 1 << i : 0);
			cyc(4);
			io(1'b0, IO_BOARD_STATUS, 8'h00);
			chk(rd, 16'(i < 5 ? 1 << i : 0));
		end
		foreach (OL[j]) begin
			io(1'b0, OL[j], 8'h00);
			chk(rd, {1'(j == 1 || j == 2), 15'h0000});
		end
		done("status");
		io(1'b1, IO_SUPPLY_CTRL, 8'hFE);
		cyc(2);
		chk(16'(supplyOff), 16'h0000);
		mac(1'b1, {MEM_SRAM_WINDOW, 15'h0000}, 16'hBEEF);
		io(1'b1, IO_SUPPLY_CTRL, 8'h01);
		cyc(1);
		chk(16'(supplyOff), 16'h0001);
		done("supply");
		mac(1'b1, MEM_HOST_IRQ_CELL, 16'hA55A);
		cyc(3);
		chk(16'(hostIrq), 16'h0000);
		host_cpu_model_i.hacc(1'b1, HOST_IRQ_SELECT, 16'h0002, rd);
		chk(16'(hostRdHit), 16'h0000);
		cyc(3);
		chk(16'(hostIrq), 16'h0004);
		host_cpu_model_i.hacc(1'b0, HOST_CLR_HOST_CELL, 16'h0000,
			rd);
		chk(rd, 16'hA55A);
		chk(16'(hostRdHit), 16'h0001);
		cyc(2);
		chk(16'(hostIrq), 16'h0000);
		host_cpu_model_i.hacc(1'b1, HOST_SET_LOCAL_CELL, 16'h1234,
			rd);
		cyc(2);
		chk(localIrq, 16'h0200);
		mac(1'b0, MEM_LOCAL_CLR_CELL, 16'h0000);
		chk(rd, 16'h1234);
		chk(16'(memRdHit), 16'h0001);
		cyc(2);
		chk(localIrq, 16'h0000);
		done("mailbox");
		foreach (PG[k]) begin
			io(1'b1, IO_SRAM_PAGE, {3'b000, PG[k]});
			mac(1'b1, {MEM_SRAM_WINDOW, 15'h4321}, 16'h0F0F);
			chk({sramSel, sramWe, 9'h000, sramAddr[19:15]},
				{2'b11, 9'h000, PG[k]});
			chk({1'b0, sramAddr[14:0]}, 16'h4321);
		end
		@(posedge sys_clk);
		pins.powerGood <= 1'b0;
		cyc(5);
		mac(1'b1, {MEM_SRAM_WINDOW, 15'h0010}, 16'h0000);
		chk(16'(sramSel), 16'h0000);
		done("sram");
		io(1'b1, IO_DIAG_PORT, 8'h0A);
		seg_chk(8'h0A);
		io(1'b1, IO_OPERATING_PORT, 8'h38);
		seg_chk(8'h0A);
		io(1'b1, IO_DISPLAY_CTRL, 8'h10);
		seg_chk(8'h38);
		io(1'b1, IO_ERROR_PORT, 8'h12);
		for (int i = 0; i < 15; i++)
			seg_chk(8'h38);
		io(1'b1, IO_ERROR_PORT, 8'h83);
		n = 0;
		while (segLow !== SEG[3] && n < 40) begin
			cyc(1);
			n++;
		end
		chk({segHigh, 2'b00, segLow}, {SEG[8], 2'b00, SEG[3]});
		n = 0;
		while (segLow === SEG[3] && n < 40) begin
			cyc(1);
			n++;
		end
		chk(16'(n > 18 && n < 22), 16'h0001);
		io(1'b1, IO_ERROR_PORT, 8'h00);
		seg_chk(8'h38);
		done("display");
		@(posedge sys_clk);
		pins.hostNmiJumper <= 1'b1;
		io(1'b1, IO_NMI_LOW, 8'h03);
		io(1'b1, IO_NMI_HIGH, 8'h00);
		n = 0;
		while (nmiLocal !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		chk({14'h0000, nmiLocal, nmiHost}, 16'h0003);
		n = 0;
		cyc(1);
		while (nmiLocal !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		chk(16'(n), 16'h000B);
		io(1'b1, IO_NMI_LOW, 8'h00);
		n = 0;
		repeat (60) begin
			cyc(1);
			n += (nmiLocal === 1'b1);
		end
		chk(16'(n), 16'h0000);
		done("nmi");
		mac(1'b1, MEM_HOST_IRQ_CELL, 16'h0001);
		@(posedge sys_clk);
		pins.resetKey <= 1'b1;
		cyc(6);
		chk({8'h00, localCpuReset, hostIrq}, 16'h0084);
		@(posedge sys_clk);
		pins.resetKey <= 1'b0;
		cyc(6);
		chk(16'(localCpuReset), 16'h0000);
		done("reset key");
		end_sim();
	end
endmodule

/* hdl/local_bus_periphery_logic.sv */
`timescale 1ns/1ps

// What this block does
// - local word write raises host interrupt if enabled
// - host read of that cell drops interrupt
// - local read of clear cell drops local interrupt
// - both cells still store and return data
// - local interrupt leaves only on jumpered lines
// - sram reached as 32 pages of 32KB
// - sram blocked while supply below threshold
// - control bit selects diagnostic or operating display
// - two hex digits, blank zero upper digit
// - error byte bit7 alternates display every 2s
// - error byte bit7 clear has no effect
// - status port returns switches, battery, mains
// - mains indication appears in status bit 0
// - battery low drives its status bit high
// - supply control bit0 asserts shutdown line
// - charge warning readable in status port
// - nonzero 16-bit interval gives periodic nmi
// - host nmi jumper copies nmi to host
// - reset key resets local cpu only
// - optical link master decodes 280h-29fh i/o
module local_bus_periphery_logic
	import local_bus_pkg::*;
#(
	parameter int ERR_ALT_COUNT  = ERR_ALT_CYCLES,
	parameter int NMI_TICK_COUNT = NMI_TICK_CYCLES,
	parameter bit OPTLINK_IN_MEM = 1'b0,
	parameter logic [19:0] OPTLINK_MEM_BASE = 20'hC_8000
)(
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        ioWr,
	input  wire logic        ioRd,
	input  wire logic [9:0]  ioAddr,
	input  wire logic [7:0]  ioWrData,
	output logic      [7:0]  ioRdData,
	input  wire logic        memWr,
	input  wire logic        memRd,
	input  wire logic [19:0] memAddr,
	input  wire logic [15:0] memWrData,
	output logic      [15:0] memRdData,
	output logic             memRdHit,
	input  wire logic        hostWr,
	input  wire logic        hostRd,
	input  wire logic [12:0] hostAddr,
	input  wire logic [15:0] hostWrData,
	output logic      [15:0] hostRdData,
	output logic             hostRdHit,
	output logic      [6:0]  hostIrq,
	output logic      [15:0] localIrq,
	output logic             sramSel,
	output logic             sramWe,
	output logic      [19:0] sramAddr,
	output logic      [6:0]  segHigh,
	output logic      [6:0]  segLow,
	input  wire pins_s       pins,
	output logic             supplyOff,
	output logic             nmiLocal,
	output logic             nmiHost,
	output logic             localCpuReset,
	output logic             optLinkSel
);

	// two-stage synchroniser for all pin inputs
	logic [PINS_W-1:0] syncA_reg;
	logic [PINS_W-1:0] syncB_reg;
	pins_s             pinS;

	genvar gi;
	generate
		for (gi = 0; gi < PINS_W; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				syncA_reg[gi] <= pins[gi];
				syncB_reg[gi] <= syncA_reg[gi];
			end
		end
	endgenerate

	assign pinS = pins_s'(syncB_reg);

	// decodes
	logic ioWrErr;
	logic ioWrOper;
	logic ioWrDiag;
	logic ioWrCtrl;
	logic ioWrPage;
	logic ioWrSupply;
	logic ioWrNmiLo;
	logic ioWrNmiHi;
	logic memHostCell;
	logic memClrCell;
	logic memSramWin;
	logic hostSetCell;
	logic hostClrCell;
	logic hostSelCell;

	assign ioWrErr     = ioWr && ioAddr == IO_ERROR_PORT;
	assign ioWrOper    = ioWr && ioAddr == IO_OPERATING_PORT;
	assign ioWrDiag    = ioWr && ioAddr == IO_DIAG_PORT;
	assign ioWrCtrl    = ioWr && ioAddr == IO_DISPLAY_CTRL;
	assign ioWrPage    = ioWr && ioAddr == IO_SRAM_PAGE;
	assign ioWrSupply  = ioWr && ioAddr == IO_SUPPLY_CTRL;
	assign ioWrNmiLo   = ioWr && ioAddr == IO_NMI_LOW;
	assign ioWrNmiHi   = ioWr && ioAddr == IO_NMI_HIGH;
	assign memHostCell = memAddr == MEM_HOST_IRQ_CELL;
	assign memClrCell  = memAddr == MEM_LOCAL_CLR_CELL;
	assign memSramWin  = memAddr[19:15] == MEM_SRAM_WINDOW;
	assign hostSetCell = hostAddr == HOST_SET_LOCAL_CELL;
	assign hostClrCell = hostAddr == HOST_CLR_HOST_CELL;
	assign hostSelCell = hostAddr == HOST_IRQ_SELECT;

	// mailbox cells; same word as seen from both sides
	logic [15:0] hostIrqCell_reg;
	logic [15:0] localIrqCell_reg;
	logic [2:0]  hostIrqSelect_reg;
	logic        hostPending_reg;
	logic        localPending_reg;

	// local write wins a same-cycle collision on a cell
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hostIrqCell_reg  <= 16'h0000;
			localIrqCell_reg <= 16'h0000;
		end else begin
			if (memWr && memHostCell)
				hostIrqCell_reg <= memWrData;
			else if (hostWr && hostClrCell)
				hostIrqCell_reg <= hostWrData;
			if (memWr && memClrCell)
				localIrqCell_reg <= memWrData;
			else if (hostWr && hostSetCell)
				localIrqCell_reg <= hostWrData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			hostIrqSelect_reg <= HOST_IRQ_OFF;
		else if (hostWr && hostSelCell)
			hostIrqSelect_reg <= hostWrData[2:0];
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (reset)
			hostPending_reg <= 1'b0;
		else if (memWr && memHostCell)
			hostPending_reg <= 1'b1;
		else if (hostRd && hostClrCell)
			hostPending_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			localPending_reg <= 1'b0;
		else if (hostWr && hostSetCell)
			localPending_reg <= 1'b1;
		else if (memRd && memClrCell)
			localPending_reg <= 1'b0;
	end

	generate
		for (gi = 0; gi < HOST_IRQ_LINES; gi++) begin : g_host_irq
			always_ff @(posedge sys_clk) begin
				if (reset)
					hostIrq[gi] <= 1'b0;
				else
					hostIrq[gi] <= hostPending_reg &&
						hostIrqSelect_reg == 3'(gi);
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (reset)
			localIrq <= 16'h0000;
		else
			localIrq <= {16{localPending_reg}} &
				pinS.localIrqJumper;
	end

	// read data for the cells, one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			memRdData <= 16'h0000;
			memRdHit  <= 1'b0;
		end else begin
			memRdHit  <= memRd && (memHostCell || memClrCell);
			memRdData <= memClrCell ? localIrqCell_reg
				: hostIrqCell_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hostRdData <= 16'h0000;
			hostRdHit  <= 1'b0;
		end else begin
			hostRdHit  <= hostRd &&
				(hostSetCell || hostClrCell || hostSelCell);
			if (hostSelCell)
				hostRdData <= {13'h0000, hostIrqSelect_reg};
			else if (hostSetCell)
				hostRdData <= localIrqCell_reg;
			else
				hostRdData <= hostIrqCell_reg;
		end
	end

	// sram paging; upper page bits are ignored by design
	logic [7:0] sramPage_reg;

	always_ff @(posedge sys_clk) begin
		if (reset)
			sramPage_reg <= BYTE_RESET;
		else if (ioWrPage)
			sramPage_reg <= ioWrData;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sramSel  <= 1'b0;
			sramWe   <= 1'b0;
			sramAddr <= 20'h0_0000;
		end else begin
			sramSel  <= (memRd || memWr) && memSramWin &&
				pinS.powerGood;
			sramWe   <= memWr && memSramWin && pinS.powerGood;
			sramAddr <= {sramPage_reg[SRAM_PAGE_BITS-1:0],
				memAddr[SRAM_OFFSET_BITS-1:0]};
		end
	end

	// display
	logic [7:0] errByte_reg;
	logic [7:0] operByte_reg;
	logic [7:0] diagByte_reg;
	logic [7:0] dispCtrl_reg;
	phase_e     phase_reg;
	logic [31:0] altCount_reg;
	logic [7:0] mainByte;
	logic [7:0] shownByte;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			errByte_reg  <= BYTE_RESET;
			operByte_reg <= BYTE_RESET;
			diagByte_reg <= BYTE_RESET;
			dispCtrl_reg <= DISPLAY_CTRL_RESET;
		end else begin
			if (ioWrErr)
				errByte_reg <= ioWrData;
			if (ioWrOper)
				operByte_reg <= ioWrData;
			if (ioWrDiag)
				diagByte_reg <= ioWrData;
			if (ioWrCtrl)
				dispCtrl_reg <= ioWrData;
		end
	end

	assign mainByte = dispCtrl_reg[DISPLAY_SOURCE_BIT] ? operByte_reg
		: diagByte_reg;

	// alternation stops at once when the error byte loses bit 7
	always_ff @(posedge sys_clk) begin
		if (reset || !errByte_reg[ALTERNATE_DISPLAY_BIT]) begin
			phase_reg    <= SHOW_MAIN;
			altCount_reg <= 32'h0000_0000;
		end else if (altCount_reg == 32'(ERR_ALT_COUNT - 1)) begin
			altCount_reg <= 32'h0000_0000;
			case (phase_reg)
				SHOW_MAIN:  phase_reg <= SHOW_ERROR;
				SHOW_ERROR: phase_reg <= SHOW_MAIN;
				default:    phase_reg <= SHOW_MAIN;
			endcase
		end else begin
			altCount_reg <= altCount_reg + 32'h0000_0001;
		end
	end

	assign shownByte = (phase_reg == SHOW_ERROR) ? errByte_reg : mainByte;

	// segment order gfedcba, active high
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			segHigh <= 7'h00;
			segLow  <= 7'h00;
		end else begin
			segHigh <= (shownByte[7:4] == 4'h0) ? 7'h00
				: hexSegments(shownByte[7:4]);
			segLow  <= hexSegments(shownByte[3:0]);
		end
	end

	// status port and supply shutdown
	logic [7:0] statusByte;

	always_comb begin
		statusByte                     = 8'h00;
		statusByte[ST_MAINS_BIT]       = pinS.mainsOk;
		statusByte[ST_UPDATE_BIT]      = pinS.updateSw;
		statusByte[ST_RUN_BIT]         = pinS.runSw;
		statusByte[ST_BATTERY_LOW_BIT] = pinS.batteryLow;
		statusByte[ST_CHARGE_WARN_BIT] = pinS.chargeWarn;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			ioRdData <= 8'h00;
		else if (ioRd && ioAddr == IO_BOARD_STATUS)
			ioRdData <= statusByte;
		else
			ioRdData <= 8'h00;
	end

	// shutdown is sticky: once ordered, the supply stays off
	always_ff @(posedge sys_clk) begin
		if (reset)
			supplyOff <= 1'b0;
		else if (ioWrSupply && ioWrData[SHUTDOWN_BIT])
			supplyOff <= 1'b1;
	end

	// nmi timer
	logic [15:0] nmiInterval_reg;
	logic [15:0] nmiCount_reg;
	logic [15:0] tickCount_reg;
	logic        tick;
	logic        nmiFire;

	always_ff @(posedge sys_clk) begin
		if (reset)
			nmiInterval_reg <= NMI_INTERVAL_RESET;
		else if (ioWrNmiLo)
			nmiInterval_reg[7:0] <= ioWrData;
		else if (ioWrNmiHi)
			nmiInterval_reg[15:8] <= ioWrData;
	end

	always_ff @(posedge sys_clk) begin
		if (reset || tick)
			tickCount_reg <= 16'h0000;
		else
			tickCount_reg <= tickCount_reg + 16'h0001;
	end

	assign tick = tickCount_reg == 16'(NMI_TICK_COUNT - 1);
	assign nmiFire = tick && nmiInterval_reg != 16'h0000 &&
		nmiCount_reg <= 16'h0001;

	// a new nonzero interval takes effect at the next expiry; zero stops the nmi at once
	always_ff @(posedge sys_clk) begin
		if (reset || nmiInterval_reg == 16'h0000)
			nmiCount_reg <= 16'h0000;
		else if (nmiFire)
			nmiCount_reg <= nmiInterval_reg;
		else if (tick)
			nmiCount_reg <= nmiCount_reg - 16'h0001;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			nmiLocal <= 1'b0;
			nmiHost  <= 1'b0;
		end else begin
			nmiLocal <= nmiFire;
			nmiHost  <= nmiFire && pinS.hostNmiJumper;
		end
	end

	// local reset key reaches only the local cpu; no host reset exists
	always_ff @(posedge sys_clk) begin
		if (reset)
			localCpuReset <= 1'b0;
		else
			localCpuReset <= pinS.resetKey;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			optLinkSel <= 1'b0;
		else if (OPTLINK_IN_MEM)
			optLinkSel <= (memRd || memWr) &&
				memAddr[19:5] == OPTLINK_MEM_BASE[19:5];
		else
			optLinkSel <= (ioRd || ioWr) &&
				ioAddr >= IO_OPTLINK_FIRST &&
				ioAddr <= IO_OPTLINK_LAST;
	end

	// relies on software: supplyOff has no save interlock
endmodule

/* hdl/local_bus_pkg.sv */
package local_bus_pkg;

	// local i/o map (byte addresses on the local bus)
	localparam logic [9:0] IO_ERROR_PORT     = 10'h078;
	localparam logic [9:0] IO_OPERATING_PORT = 10'h079;
	localparam logic [9:0] IO_DIAG_PORT      = 10'h080;
	localparam logic [9:0] IO_DISPLAY_CTRL   = 10'h223;
	localparam logic [9:0] IO_SRAM_PAGE      = 10'h228;
	localparam logic [9:0] IO_BOARD_STATUS   = 10'h234;
	localparam logic [9:0] IO_SUPPLY_CTRL    = 10'h235;
	localparam logic [9:0] IO_NMI_LOW        = 10'h237;
	localparam logic [9:0] IO_NMI_HIGH       = 10'h238;
	localparam logic [9:0] IO_OPTLINK_FIRST  = 10'h280;
	localparam logic [9:0] IO_OPTLINK_LAST   = 10'h29F;

	// local memory map
	localparam logic [19:0] MEM_HOST_IRQ_CELL  = 20'hD_1FFE;
	localparam logic [19:0] MEM_LOCAL_CLR_CELL = 20'hD_1FFC;
	localparam logic [4:0]  MEM_SRAM_WINDOW    = 5'h1B;
	localparam int          SRAM_PAGE_BITS     = 5;
	localparam int          SRAM_OFFSET_BITS   = 15;

	// host side dp-ram offsets (within the 8 KB page)
	localparam logic [12:0] HOST_SET_LOCAL_CELL = 13'h1FFC;
	localparam logic [12:0] HOST_CLR_HOST_CELL  = 13'h1FFE;
	localparam logic [12:0] HOST_IRQ_SELECT     = 13'h1FFA;
	localparam logic [2:0]  HOST_IRQ_OFF        = 3'h7;
	localparam int          HOST_IRQ_LINES      = 7;

	// field positions
	localparam int DISPLAY_SOURCE_BIT    = 4;
	localparam int ALTERNATE_DISPLAY_BIT = 7;
	localparam int SHUTDOWN_BIT          = 0;
	localparam int ST_MAINS_BIT          = 0;
	localparam int ST_UPDATE_BIT         = 1;
	localparam int ST_RUN_BIT            = 2;
	localparam int ST_BATTERY_LOW_BIT    = 3;
	localparam int ST_CHARGE_WARN_BIT    = 4;

	// reset values
	localparam logic [7:0]  DISPLAY_CTRL_RESET = 8'h00;
	localparam logic [15:0] NMI_INTERVAL_RESET = 16'h0000;
	localparam logic [7:0]  BYTE_RESET         = 8'h00;

	// timing
	localparam int CLK_FREQ_KHZ      = 125_000;
	localparam int ERR_ALT_TIME_MS   = 2_000;
	localparam int ERR_ALT_CYCLES    = ERR_ALT_TIME_MS * CLK_FREQ_KHZ;
	localparam int NMI_TICK_TIME_US  = 1;
	localparam int NMI_TICK_CYCLES   = NMI_TICK_TIME_US * CLK_FREQ_KHZ / 1000;

	// pin inputs, all asynchronous to sys_clk
	typedef struct packed {
		logic        powerGood;
		logic        mainsOk;
		logic        batteryLow;
		logic        chargeWarn;
		logic        updateSw;
		logic        runSw;
		logic        resetKey;
		logic        hostNmiJumper;
		logic [15:0] localIrqJumper;
	} pins_s;

	localparam int PINS_W = $bits(pins_s);

	typedef enum logic {
		SHOW_MAIN  = 1'b0,
		SHOW_ERROR = 1'b1
	} phase_e;

	// segment order gfedcba, active high
	function automatic logic [6:0] hexSegments(input logic [3:0] nib);
		case (nib)
			4'h0: hexSegments = 7'h3F;
			4'h1: hexSegments = 7'h06;
			4'h2: hexSegments = 7'h5B;
			4'h3: hexSegments = 7'h4F;
			4'h4: hexSegments = 7'h66;
			4'h5: hexSegments = 7'h6D;
			4'h6: hexSegments = 7'h7D;
			4'h7: hexSegments = 7'h07;
			4'h8: hexSegments = 7'h7F;
			4'h9: hexSegments = 7'h6F;
			4'hA: hexSegments = 7'h77;
			4'hB: hexSegments = 7'h7C;
			4'hC: hexSegments = 7'h39;
			4'hD: hexSegments = 7'h5E;
			4'hE: hexSegments = 7'h79;
			default: hexSegments = 7'h71;
		endcase
	endfunction

endpackage
